//--- core/ftbsp_port.sv
// Flow-through burst SRAM port with zero turnaround and flip-flop storage
`timescale 1ns/1ps
`default_nettype none
module ftbsp_port #(
  parameter int MEM_WORDS = 1 << ftbsp_pkg::ADDR_W
) (
  // Clock and power-up reset
  input  wire logic                         core_clk,
  input  wire logic                         srst,
  // Synchronous controls
  input  wire logic                         clk_qualify_n,
  input  wire ftbsp_pkg::ftbsp_ctrl_t       bus_ctrl,
  input  wire logic [ftbsp_pkg::ADDR_W-1:0] addr,
  input  wire logic                         burst_order,
  // Asynchronous controls
  input  wire logic                         output_drive_enable_n,
  input  wire logic                         sleep_request,
  // Data lines
  input  wire logic [ftbsp_pkg::DATA_W-1:0] dq_i,
  output logic      [ftbsp_pkg::DATA_W-1:0] dq_o,
  output logic                              dq_oe_n,
  // Parity lines
  input  wire logic [ftbsp_pkg::LANES-1:0]  parity_lines_i,
  output logic      [ftbsp_pkg::LANES-1:0]  parity_lines_o,
  output logic                              parity_lines_oe_n,
  // Status
  output logic                              sleep_active
);
  import ftbsp_pkg::*;

  localparam int IDX_W = (MEM_WORDS > 1) ? $clog2(MEM_WORDS) : 1;

  function automatic logic [IDX_W-1:0] idx(input logic [ADDR_W-1:0] a);
    idx = a[IDX_W-1:0];
  endfunction

  // Merge bus data into a stored word lane by lane
  function automatic logic [WORD_W-1:0] merge(input logic [WORD_W-1:0] old,
                                              input logic [DATA_W-1:0] d,
                                              input logic [LANES-1:0]  p,
                                              input logic [LANES-1:0]  lane_n);
    logic [WORD_W-1:0] w;
    w = old;
    for (int i = 0; i < LANES; i++) begin
      if (!lane_n[i]) begin
        w[i*BYTE_W +: BYTE_W] = d[i*BYTE_W +: BYTE_W];
        w[DATA_W + i]         = p[i];
      end
    end
    merge = w;
  endfunction

  logic [WORD_W-1:0] mem [MEM_WORDS];

  ftbsp_state_t      state_r;
  ftbsp_state_t      state_nxt;
  ftbsp_wr_t         wr_r;
  ftbsp_wr_t         wr_nxt;
  logic [ADDR_W-1:0] addr_r;
  logic [WORD_W-1:0] rd_q_r;
  logic              drive_r;
  logic              drive_nxt;
  logic              sleep_s1_r;
  logic              sleep_s2_r;
  logic [LOW_W-1:0]  next_low;

  // Operation decode
  wire qual       = ~clk_qualify_n;
  wire sleep_now  = sleep_s2_r;
  wire halt       = sleep_now | (state_r == ST_SLEEP);
  wire all_sel    = ~bus_ctrl.chip_select_a_n & bus_ctrl.chip_select_b & ~bus_ctrl.chip_select_c_n;
  wire load_op    = qual & ~bus_ctrl.advance_or_load & ~halt;
  wire adv_op     = qual & bus_ctrl.advance_or_load & ~halt;
  wire desel_op   = load_op & ~all_sel;
  wire rd_begin   = load_op & all_sel & bus_ctrl.write_strobe_n;
  wire wr_begin   = load_op & all_sel & ~bus_ctrl.write_strobe_n;
  wire rd_cont    = adv_op & (state_r == ST_READ);
  wire wr_cont    = adv_op & (state_r == ST_WRITE);
  wire burst_load = rd_begin | wr_begin;
  wire burst_adv  = rd_cont | wr_cont;
  wire fetch      = rd_begin | rd_cont;
  wire commit     = qual & ~sleep_now & wr_r.valid;

  wire [ADDR_W-1:0] eff_addr = burst_load ? addr : {addr_r[ADDR_W-1:LOW_W], next_low};
  wire [WORD_W-1:0] wr_word  = merge(mem[idx(wr_r.addr)], dq_i, parity_lines_i, wr_r.lane_n);
  wire              bypass   = commit & (wr_r.addr == eff_addr);
  wire [WORD_W-1:0] rd_word  = bypass ? wr_word : mem[idx(eff_addr)];
  wire [WORD_W-1:0] wr_old   = mem[idx(wr_r.addr)];
  wire [WORD_W-1:0] ld_old   = mem[idx(addr)];

  ftbsp_burst_ctr u_burst (
    .core_clk  (core_clk),
    .srst      (srst),
    .load      (burst_load),
    .advance   (burst_adv),
    .order_il  (burst_order),
    .start_low (addr[LOW_W-1:0]),
    .next_low  (next_low)
  );

  // Next state: sleep first, then stall, then the sampled operation
  always_comb begin
    state_nxt = state_r;
    if (sleep_now) begin
      state_nxt = ST_SLEEP;
    end else if (state_r == ST_SLEEP) begin
      state_nxt = ST_DESEL;
    end else if (!qual) begin
      state_nxt = state_r;
    end else if (desel_op) begin
      state_nxt = ST_DESEL;
    end else if (rd_begin) begin
      state_nxt = ST_READ;
    end else if (wr_begin) begin
      state_nxt = ST_WRITE;
    end
  end

  // Pending write: address and lanes wait one edge for their data
  always_comb begin
    wr_nxt = wr_r;
    if (sleep_now) begin
      wr_nxt = WR_RST;
    end else if (!qual) begin
      wr_nxt = wr_r;
    end else if (wr_begin || wr_cont) begin
      wr_nxt = '{valid: 1'b1, lane_n: bus_ctrl.byte_lane_write_n, addr: eff_addr};
    end else begin
      wr_nxt = WR_RST;
    end
  end

  // Drivers turn on in the cycle after a read fetch and stay on through stalled edges
  always_comb begin
    drive_nxt = drive_r;
    if (sleep_now) begin
      drive_nxt = 1'b0;
    end else if (!qual) begin
      drive_nxt = drive_r;
    end else begin
      drive_nxt = fetch;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_r <= ST_DESEL;
      wr_r    <= WR_RST;
      drive_r <= 1'b0;
      addr_r  <= ADDR_RST;
      rd_q_r  <= WORD_RST;
    end else begin
      state_r <= state_nxt;
      wr_r    <= wr_nxt;
      drive_r <= drive_nxt;
      if (burst_load || burst_adv) begin
        addr_r <= eff_addr;
      end
      if (fetch) begin
        rd_q_r <= rd_word;
      end
    end
  end

  // Storage is retained through reset and sleep
  always_ff @(posedge core_clk) begin
    if (!srst && commit) begin
      mem[idx(wr_r.addr)] <= wr_word;
    end
  end

  // Two-stage synchroniser for the asynchronous sleep request
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sleep_s1_r <= 1'b0;
      sleep_s2_r <= 1'b0;
    end else begin
      sleep_s1_r <= sleep_request;
      sleep_s2_r <= sleep_s1_r;
    end
  end

  // Output enable is gated combinationally, so it acts without the clock
  assign dq_o              = rd_q_r[DATA_W-1:0];
  assign parity_lines_o    = rd_q_r[WORD_W-1:DATA_W];
  assign dq_oe_n           = ~(drive_r & ~output_drive_enable_n);
  assign parity_lines_oe_n = ~(drive_r & ~output_drive_enable_n);
  assign sleep_active      = sleep_s2_r;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence s_il_load;
    qual && !sleep_now && burst_load && burst_order;
  endsequence

  sequence s_il_adv;
    qual && !sleep_now && burst_order && bus_ctrl.advance_or_load;
  endsequence

  sequence s_wr_load;
    wr_begin;
  endsequence

  sequence s_rd_load;
    rd_begin;
  endsequence

  sequence s_stall;
    clk_qualify_n && !halt;
  endsequence

  sequence s_sleep_exit;
    state_r == ST_SLEEP && !sleep_now;
  endsequence

  stall_hold_a: assert property (clk_qualify_n && !sleep_now && state_r != ST_SLEEP |=>
      $stable(state_r) && $stable(addr_r) && $stable(wr_r) && $stable(drive_r) && $stable(rd_q_r))
    else $error("stalled edge changed internal state");

  read_begin_a: assert property (rd_begin |=> drive_r && addr_r == $past(addr) && state_r == ST_READ)
    else $error("read begin not captured");

  oe_gate_a: assert property (output_drive_enable_n || !drive_r |-> dq_oe_n && parity_lines_oe_n)
    else $error("lines driven without output enable");

  desel_off_a: assert property (desel_op |=> dq_oe_n && state_r == ST_DESEL)
    else $error("deselect did not tri-state");

  write_tri_a: assert property (s_wr_load |=> !drive_r && wr_r.valid && dq_oe_n && parity_lines_oe_n)
    else $error("lines driven during write");

  linear_step_a: assert property (burst_adv && !burst_order |=>
      addr_r[LOW_W-1:0] == LOW_W'($past(addr_r[LOW_W-1:0]) + LOW_ONE))
    else $error("linear burst step wrong");

  interleave_a: assert property (s_il_load ##1 s_il_adv [*3] |=>
      state_r == ST_DESEL || addr_r[LOW_W-1:0] == ($past(addr_r[LOW_W-1:0], 3) ^ LOW_LAST))
    else $error("interleaved burst sequence wrong");

  dir_keep_a: assert property (burst_adv |=> state_r == $past(state_r))
    else $error("burst direction changed");

  commit_a: assert property (commit |=> mem[idx($past(wr_r.addr))] == $past(wr_word))
    else $error("write data not stored");

  sleep_in_a: assert property (sleep_request [*2] |=> sleep_active ##1 state_r == ST_SLEEP && dq_oe_n)
    else $error("sleep not entered in two cycles");

  sleep_out_a: assert property (!sleep_request [*2] |=> !sleep_active)
    else $error("sleep not left in two cycles");

  powerup_a: assert property (disable iff (1'b0) srst |=> dq_oe_n && parity_lines_oe_n && state_r == ST_DESEL)
    else $error("not deselected after reset");

  rd_then_wr_a: assert property (s_rd_load ##1 s_wr_load |=> wr_r.valid && state_r == ST_WRITE)
    else $error("write after read not accepted");

  rd_then_rd_a: assert property (s_rd_load ##1 s_rd_load |=> drive_r && state_r == ST_READ)
    else $error("read after read not accepted");

  rd_data_a: assert property (rd_begin && !commit |=> rd_q_r == $past(ld_old))
    else $error("read data not fetched");

  adv_ignore_a: assert property (burst_adv && !all_sel |=>
      state_r == $past(state_r) && state_r != ST_DESEL)
    else $error("advance obeyed the selects");

  adv_upper_a: assert property (burst_adv |=>
      addr_r[ADDR_W-1:LOW_W] == $past(addr_r[ADDR_W-1:LOW_W]))
    else $error("burst changed upper address bits");

  wrap_four_a: assert property (s_il_load ##1 s_il_adv [*4] |=>
      addr_r[LOW_W-1:0] == $past(addr_r[LOW_W-1:0], 4))
    else $error("burst did not wrap after four beats");

  wr_addr_a: assert property (s_wr_load |=>
      wr_r.addr == $past(addr) && wr_r.lane_n == $past(bus_ctrl.byte_lane_write_n))
    else $error("write address or lanes not captured");

  wr_phase_tri_a: assert property (wr_r.valid |-> dq_oe_n && parity_lines_oe_n)
    else $error("lines driven in a write data phase");

  wr_oe_mask_a: assert property (wr_r.valid && !output_drive_enable_n |-> dq_oe_n && parity_lines_oe_n)
    else $error("output enable not masked in write");

  rd_drive_a: assert property (drive_r && !output_drive_enable_n |-> !dq_oe_n && !parity_lines_oe_n)
    else $error("read data not driven");

  desel_tri_a: assert property (state_r == ST_DESEL |-> dq_oe_n && parity_lines_oe_n)
    else $error("lines driven while deselected");

  lane_keep_a: assert property (commit && wr_r.lane_n[0] |=>
      mem[idx($past(wr_r.addr))][BYTE_W-1:0] == $past(wr_old[BYTE_W-1:0]))
    else $error("unselected byte lane changed");

  parity_keep_a: assert property (commit && wr_r.lane_n[LANES-1] |=>
      mem[idx($past(wr_r.addr))][WORD_W-1] == $past(wr_old[WORD_W-1]))
    else $error("unselected parity bit changed");

  lane_write_a: assert property (commit && !wr_r.lane_n[0] |=>
      mem[idx($past(wr_r.addr))][BYTE_W-1:0] == $past(dq_i[BYTE_W-1:0]) &&
      mem[idx($past(wr_r.addr))][DATA_W] == $past(parity_lines_i[0]))
    else $error("selected byte lane not written");

  stall_data_a: assert property (s_stall |=>
      $stable(dq_o) && $stable(parity_lines_o) && $stable(drive_r))
    else $error("stalled edge changed the output");

  stall_mem_a: assert property (s_stall |=> mem[idx($past(wr_r.addr))] == $past(wr_old))
    else $error("stalled edge wrote the array");

  sleep_drop_a: assert property (sleep_now |=> state_r == ST_SLEEP && !wr_r.valid && !drive_r)
    else $error("pending access kept in sleep");

  sleep_exit_a: assert property (s_sleep_exit |=> state_r == ST_DESEL && !wr_r.valid && !drive_r)
    else $error("sleep exit edge started an access");

  commit_free_a: assert property (commit && !wr_begin && !wr_cont |=> !wr_r.valid)
    else $error("completed write left pending");

endmodule
`default_nettype wire

//--- core/ftbsp_pkg.sv
// Constants, states and carrier types of the flow-through burst SRAM port
package ftbsp_pkg;

  // Array geometry
  localparam int ADDR_W  = 19;
  localparam int LANES   = 4;
  localparam int BYTE_W  = 8;
  localparam int DATA_W  = LANES * BYTE_W;
  localparam int WORD_W  = DATA_W + LANES;
  localparam int LOW_W   = 2;

  // Reset values and burst step constants
  localparam logic [LOW_W-1:0]  LOW_ZERO   = 2'h0;
  localparam logic [LOW_W-1:0]  LOW_ONE    = 2'h1;
  localparam logic [LOW_W-1:0]  LOW_LAST   = 2'h3;
  localparam logic [ADDR_W-1:0] ADDR_RST   = 19'h0;
  localparam logic [WORD_W-1:0] WORD_RST   = 36'h0;
  localparam logic [LANES-1:0]  LANES_OFF  = 4'hF;

  // Sleep entry and exit latency in clock cycles
  localparam int SLEEP_CYC = 2;

  typedef enum logic [3:0] {
    ST_DESEL = 4'h1,
    ST_READ  = 4'h2,
    ST_WRITE = 4'h4,
    ST_SLEEP = 4'h8
  } ftbsp_state_t;

  // Synchronous control pins sampled at the clock rise
  typedef struct packed {
    logic             chip_select_a_n;
    logic             chip_select_b;
    logic             chip_select_c_n;
    logic             advance_or_load;
    logic             write_strobe_n;
    logic [LANES-1:0] byte_lane_write_n;
  } ftbsp_ctrl_t;

  // Write waiting for its data phase
  typedef struct packed {
    logic              valid;
    logic [LANES-1:0]  lane_n;
    logic [ADDR_W-1:0] addr;
  } ftbsp_wr_t;

  localparam ftbsp_wr_t WR_RST = '{valid: 1'b0, lane_n: LANES_OFF, addr: ADDR_RST};

endpackage

//--- core/ftbsp_burst_ctr.sv
// Two-bit burst sequencer, linear or interleaved
`timescale 1ns/1ps
`default_nettype none
module ftbsp_burst_ctr (
  // Clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       srst,
  // Sequencing control
  input  wire logic                       load,
  input  wire logic                       advance,
  input  wire logic                       order_il,
  input  wire logic [ftbsp_pkg::LOW_W-1:0] start_low,
  // Next low address bits
  output logic      [ftbsp_pkg::LOW_W-1:0] next_low
);
  import ftbsp_pkg::*;

  logic [LOW_W-1:0] start_r;
  logic [LOW_W-1:0] cnt_r;
  wire  [LOW_W-1:0] cnt_inc = LOW_W'(cnt_r + LOW_ONE);

  // Interleaved xors the step into the start, linear adds it modulo four
  assign next_low = order_il ? (start_r ^ cnt_inc) : LOW_W'(start_r + cnt_inc);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      start_r <= LOW_ZERO;
      cnt_r   <= LOW_ZERO;
    end else if (load) begin
      start_r <= start_low;
      cnt_r   <= LOW_ZERO;
    end else if (advance) begin
      cnt_r   <= cnt_inc;
    end
  end

endmodule
`default_nettype wire

//--- test/ftbsp_master.sv
// Bus master model for the flow-through burst SRAM port
`timescale 1ns/1ps
`default_nettype none
module ftbsp_master (
  // Clock
  input  wire logic                         core_clk,
  // Synchronous pins
  output logic                              clk_qualify_n,
  output ftbsp_pkg::ftbsp_ctrl_t            bus_ctrl,
  output logic      [ftbsp_pkg::ADDR_W-1:0] addr,
  // Shared data and parity lines
  output logic      [ftbsp_pkg::DATA_W-1:0] dq_i,
  output logic      [ftbsp_pkg::LANES-1:0]  parity_lines_i,
  input  wire logic [ftbsp_pkg::DATA_W-1:0] dq_o,
  input  wire logic                         dq_oe_n,
  input  wire logic [ftbsp_pkg::LANES-1:0]  parity_lines_o,
  input  wire logic                         parity_lines_oe_n
);
  import ftbsp_pkg::*;
  logic [WORD_W-1:0] m_word;
  // Device drive wins, else master data, else a released bus that toggles
  assign dq_i           = dq_oe_n ? m_word[DATA_W-1:0] : dq_o;
  assign parity_lines_i = parity_lines_oe_n ? m_word[WORD_W-1:DATA_W] : parity_lines_o;
  initial begin
    clk_qualify_n = 1'h0;
    bus_ctrl      = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 4'hF};
    addr          = '0;
    m_word        = '0;
  end
  // One bus cycle; write data rides with the cycle after its address
  task automatic cyc(input ftbsp_ctrl_t c, input logic [ADDR_W-1:0] a, input logic den,
                     input logic [WORD_W-1:0] wd, input logic stall);
    clk_qualify_n <= stall;
    bus_ctrl      <= c;
    addr          <= a;
    m_word        <= den ? wd : ~m_word;
    @(posedge core_clk);
    #1;
  endtask
endmodule
`default_nettype wire

//--- test/tb_top.sv
// Self-checking testbench for the flow-through burst SRAM port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ftbsp_pkg::*;
  localparam int WORDS = 64;
  logic              core_clk, srst, burst_order, output_drive_enable_n, sleep_request;
  logic              clk_qualify_n, dq_oe_n, parity_lines_oe_n, sleep_active;
  ftbsp_ctrl_t       bus_ctrl, ds, rd;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] dq_i, dq_o;
  logic [LANES-1:0]  parity_lines_i, parity_lines_o;
  logic [WORD_W-1:0] mem [WORDS];
  int                error_cnt = 0;
  int                checks_done = 0;

  ftbsp_port #(.MEM_WORDS(WORDS)) uut (
    .core_clk(core_clk), .srst(srst), .clk_qualify_n(clk_qualify_n), .bus_ctrl(bus_ctrl),
    .addr(addr), .burst_order(burst_order), .output_drive_enable_n(output_drive_enable_n),
    .sleep_request(sleep_request), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_n(dq_oe_n),
    .parity_lines_i(parity_lines_i), .parity_lines_o(parity_lines_o),
    .parity_lines_oe_n(parity_lines_oe_n), .sleep_active(sleep_active));
  ftbsp_master master (
    .core_clk(core_clk), .clk_qualify_n(clk_qualify_n), .bus_ctrl(bus_ctrl), .addr(addr),
    .dq_i(dq_i), .parity_lines_i(parity_lines_i), .dq_o(dq_o), .dq_oe_n(dq_oe_n),
    .parity_lines_o(parity_lines_o), .parity_lines_oe_n(parity_lines_oe_n));

  function automatic ftbsp_ctrl_t ct(input logic sel, input logic adv, input logic wr_n,
                                     input logic [3:0] ln);
    return '{!sel, sel, !sel, adv, wr_n, ln};
  endfunction

  task automatic chk(input string nm, input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a);
    master.cyc(rd, a, 1'h0, '0, 1'h0);
    chk("rd_data", {parity_lines_o, dq_o}, mem[a[5:0]]);
    chk("rd_oe_n", {dq_oe_n, parity_lines_oe_n}, 2'h0);
  endtask

  task automatic wr1(input logic [ADDR_W-1:0] a, input logic [3:0] ln, input logic [WORD_W-1:0] wd);
    master.cyc(ct(1'h1, 1'h0, 1'h0, ln), a, 1'h0, '0, 1'h0);
    chk("wr_oe_n", {dq_oe_n, parity_lines_oe_n}, 2'h3);
    master.cyc(ds, a, 1'h1, wd, 1'h0);
    for (int l = 0; l < LANES; l++) begin
      if (!ln[l]) begin
        mem[a[5:0]][8*l+:8]   = wd[8*l+:8];
        mem[a[5:0]][DATA_W+l] = wd[DATA_W+l];
      end
    end
  endtask

  // Load plus n-1 advances; advances carry inactive selects and a flipped strobe
  task automatic burst(input logic o, input logic [ADDR_W-1:0] a, input logic wr, input int n);
    logic [ADDR_W-1:0] ad;
    logic [WORD_W-1:0] wd;
    wd = '0;
    burst_order <= o;
    for (int i = 0; i < n; i++) begin
      ad = {a[ADDR_W-1:2], o ? a[1:0] ^ i[1:0] : a[1:0] + i[1:0]};
      master.cyc(i == 0 ? ct(1'h1, 1'h0, !wr, 4'h0) : ct(1'h0, 1'h1, wr, 4'h0),
                 a, wr && i > 0, wd, 1'h0);
      if (wr) begin
        wd = {i[3:0], 13'h1A5, ad};
        mem[ad[5:0]] = wd;
      end else begin
        chk("burst_rd", {parity_lines_o, dq_o}, mem[ad[5:0]]);
      end
    end
    master.cyc(ds, a, wr, wd, 1'h0);
    chk("burst_end_oe_n", {dq_oe_n, parity_lines_oe_n}, 2'h3);
  endtask

  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    #200000;
    error_cnt++;
    final_report();
  end

  initial begin
    srst = 1'h1;
    burst_order = 1'h0;
    output_drive_enable_n = 1'h0;
    sleep_request = 1'h0;
    ds = ct(1'h0, 1'h0, 1'h1, 4'hF);
    rd = ct(1'h1, 1'h0, 1'h1, 4'hF);
    repeat (8) @(posedge core_clk);
    #1 srst <= 1'h0;
    @(posedge core_clk);
    #1;
    chk("rst_out", {dq_oe_n, parity_lines_oe_n, sleep_active, dq_o}, {3'h6, 32'h0});
    // Read issued on the write's data-phase edge
    master.cyc(ct(1'h1, 1'h0, 1'h0, 4'h0), 19'h4, 1'h0, '0, 1'h0);
    master.cyc(rd, 19'h4, 1'h1, 36'h9_1234_5678, 1'h0);
    mem[4] = 36'h9_1234_5678;
    chk("rd_after_wr", {parity_lines_o, dq_o}, mem[4]);
    for (int l = 0; l < LANES; l++) begin
      wr1(19'h4, ~(4'h1 << l), {9{4'(l + 5)}});
      rd_chk(19'h4);
    end
    wr1(19'h4, 4'hF, '1);
    rd_chk(19'h4);
    output_drive_enable_n <= 1'h1;
    master.cyc(rd, 19'h4, 1'h0, '0, 1'h0);
    chk("dummy_oe_n", {dq_oe_n, parity_lines_oe_n}, 2'h3);
    output_drive_enable_n <= 1'h0;
    #1;
    chk("async_oe", {dq_oe_n, parity_lines_o, dq_o}, {1'h0, mem[4]});
    repeat (3) master.cyc(ds, 19'h0, 1'h0, '0, 1'h1);
    chk("stall_hold", {dq_oe_n, parity_lines_o, dq_o}, {1'h0, mem[4]});
    master.cyc(ct(1'h1, 1'h0, 1'h0, 4'h0), 19'h5, 1'h0, '0, 1'h0);
    repeat (2) master.cyc(ds, 19'h0, 1'h0, '0, 1'h1);
    master.cyc(ds, 19'h0, 1'h1, 36'h3_0BAD_CAFE, 1'h0);
    mem[5] = 36'h3_0BAD_CAFE;
    rd_chk(19'h5);
    for (int k = 0; k < 3; k++) begin
      rd_chk(19'h5);
      master.cyc(ftbsp_ctrl_t'(rd ^ (9'h100 >> k)), 19'h5, 1'h0, '0, 1'h0);
      chk("desel_oe_n", {dq_oe_n, parity_lines_oe_n}, 2'h3);
    end
    burst(1'h0, 19'h9, 1'h1, 5);
    burst(1'h0, 19'hB, 1'h0, 4);
    burst(1'h1, 19'h12, 1'h1, 5);
    burst(1'h1, 19'h13, 1'h0, 4);
    sleep_request <= 1'h1;
    repeat (2) master.cyc(ds, 19'h0, 1'h0, '0, 1'h0);
    chk("sleep_in", sleep_active, 1'h1);
    master.cyc(rd, 19'h5, 1'h0, '0, 1'h0);
    chk("sleep_oe_n", {dq_oe_n, parity_lines_oe_n}, 2'h3);
    sleep_request <= 1'h0;
    repeat (2) master.cyc(ds, 19'h0, 1'h0, '0, 1'h0);
    chk("sleep_out", sleep_active, 1'h0);
    repeat (2) master.cyc(ds, 19'h0, 1'h0, '0, 1'h0);
    rd_chk(19'h5);
    rd_chk(19'hB);
    final_report();
  end
endmodule
`default_nettype wire
